// [hw/csr_channel_setup.sv]
// per-channel setup registers loaded by io_processor functions
// assumes function strobe, parcel and byte strobes come from logic on
// i_sys_clk; inbound bus lines and parity error come from pins
`timescale 1ns/1ps

module csr_channel_setup
  import csr_pkg::*;
#(
  parameter int ACC_W = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // function port from the io_processor
  input wire logic i_func_valid,
  input wire logic [3:0] i_func_code,
  input wire logic [ACC_W-1:0] i_acc,
  // transfer events from the channel sequencer
  input wire logic i_byte_strobe,
  input wire logic i_transfer_end,
  input wire logic i_read_xfer,
  input wire logic i_mem_write_req,
  input wire logic [7:0] i_out_data,
  // inbound channel pins
  input wire logic [7:0] i_bus_in,
  input wire logic i_bus_in_par_err,
  // channel pins outbound
  output logic [9:0] o_tags,
  output logic [7:0] o_bus_out,
  output logic o_bus_out_par,
  output logic o_clock_out,
  output logic o_test_point,
  // status and mode towards the rest of the channel
  output logic [ACC_W-1:0] o_start_addr0,
  output logic [ACC_W-1:0] o_start_addr1,
  output logic o_addr_sel,
  output logic o_chain_en,
  output logic [ACC_W-1:0] o_byte_count,
  output logic [ACC_W-1:0] o_next_count,
  output logic [ACC_W-1:0] o_dev_addr_mode,
  output logic o_skip,
  output logic o_stack_status,
  output logic [1:0] o_chain_mode,
  output logic [1:0] o_irq_mode,
  output logic [1:0] o_protocol,
  output logic o_mem_write,
  output logic o_parity_err,
  output logic o_chain_irq,
  output logic o_count_zero_irq
);

  typedef struct packed {
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic [8:0] stable;
    logic [ACC_W-1:0] addr0;
    logic [ACC_W-1:0] addr1;
    logic sel;
    logic chain_en;
    logic chain_irq;
    logic xfer_done;
    csr_ec_type ec;
    logic [ACC_W-1:0] count;
    logic [ACC_W-1:0] next_count;
    logic [ACC_W-1:0] dev;
    logic [ACC_W-1:0] otag;
    logic force_par;
    logic test_point;
    logic zero_irq;
    logic [7:0] bus_out;
    logic bus_par;
    logic par_err;
    logic mem_we;
  } csr_state_type;

  localparam csr_state_type CSR_RST_STATE = '{
    sync1: CSR_RST_SYNC, sync2: CSR_RST_SYNC, sync3: CSR_RST_SYNC,
    stable: CSR_RST_SYNC, addr0: CSR_RST_WORD, addr1: CSR_RST_WORD,
    sel: 1'b0, chain_en: 1'b0, chain_irq: 1'b0, xfer_done: 1'b0,
    ec: CSR_EC_IDLE, count: CSR_RST_WORD, next_count: CSR_RST_WORD,
    dev: CSR_RST_WORD, otag: CSR_RST_WORD, force_par: 1'b0,
    test_point: 1'b0, zero_irq: 1'b0, bus_out: 8'h00, bus_par: 1'b1,
    par_err: 1'b0, mem_we: 1'b0};

  logic [1:0] rst_pipe_reg;
  logic rst_n;
  csr_state_type state_reg;
  csr_state_type state_next;
  logic [7:0] out_byte;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  always_comb begin
    state_next = state_reg;
    // pin synchroniser; a change counts once stages two and three agree
    state_next.sync1 = {i_bus_in_par_err, i_bus_in};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    if (state_reg.sync2 == state_reg.sync3) begin
      state_next.stable = state_reg.sync3;
    end
    state_next.zero_irq = 1'b0;
    if (i_byte_strobe) begin
      state_next.force_par = 1'b0;
    end
    if (i_func_valid) begin
      state_next.test_point = 1'b0;
      state_next.ec = CSR_EC_IDLE;
      unique case (i_func_code)
        CSR_FN_LOAD_ADDR: begin
          if (i_acc[CSR_LA_SEL_BIT]) begin
            state_next.addr1 = i_acc;
          end else begin
            state_next.addr0 = i_acc;
          end
          state_next.sel = i_acc[CSR_LA_SEL_BIT];
          if (i_acc[CSR_LA_CHAIN_BIT]) begin
            state_next.chain_en = 1'b1;
          end
          if (state_reg.xfer_done) begin
            state_next.chain_irq = 1'b0;
            state_next.xfer_done = 1'b0;
          end
          state_next.ec = CSR_EC_FIRST;
        end
        CSR_FN_ENTER_COUNT: begin
          if (state_reg.ec == CSR_EC_SECOND) begin
            state_next.next_count = i_acc;
          end else begin
            state_next.count = i_acc;
            state_next.ec = CSR_EC_SECOND;
          end
        end
        CSR_FN_DEV_ADDR: begin
          state_next.dev = i_acc;
        end
        CSR_FN_OUT_TAGS: begin
          state_next.otag = i_acc;
          state_next.force_par = i_acc[CSR_OT_FORCE_BIT];
          state_next.test_point = i_acc[CSR_OT_TEST_BIT];
        end
        default: begin
        end
      endcase
    end
    if (i_byte_strobe && state_reg.count != CSR_RST_WORD) begin
      state_next.count = state_reg.count - 1'b1;
      if (state_reg.count == 16'h0001) begin
        if (state_reg.chain_en) begin
          state_next.count = state_reg.next_count;
          state_next.sel = ~state_reg.sel;
          state_next.chain_irq = 1'b1;
        end else begin
          state_next.zero_irq = 1'b1;
        end
      end
    end
    if (i_transfer_end) begin
      state_next.chain_en = 1'b0;
      state_next.xfer_done = 1'b1;
    end
    if (state_reg.otag[CSR_OT_STROBE_BIT]) begin
      state_next.dev[7:0] = state_reg.stable[7:0];
    end
    out_byte = state_reg.otag[CSR_OT_GATE_BIT] ? state_reg.dev[7:0]
                                               : i_out_data;
    state_next.bus_out = out_byte;
    state_next.bus_par = ~(^out_byte) ^ state_reg.force_par;
    state_next.par_err = state_reg.stable[8] &
                         ~state_reg.otag[CSR_OT_INHIBIT_BIT];
    state_next.mem_we = i_mem_write_req &
                        ~(i_read_xfer & state_reg.dev[CSR_DA_SKIP_BIT]);
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CSR_RST_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tags = state_reg.otag[9:0];
  assign o_bus_out = state_reg.bus_out;
  assign o_bus_out_par = state_reg.bus_par;
  assign o_clock_out = state_reg.otag[CSR_OT_CLOCK_BIT];
  assign o_test_point = state_reg.test_point;
  assign o_start_addr0 = state_reg.addr0;
  assign o_start_addr1 = state_reg.addr1;
  assign o_addr_sel = state_reg.sel;
  assign o_chain_en = state_reg.chain_en;
  assign o_byte_count = state_reg.count;
  assign o_next_count = state_reg.next_count;
  assign o_dev_addr_mode = state_reg.dev;
  assign o_skip = state_reg.dev[CSR_DA_SKIP_BIT];
  assign o_stack_status = state_reg.dev[CSR_DA_STACK_BIT];
  assign o_chain_mode = state_reg.dev[CSR_DA_CHAIN_LSB +: 2];
  assign o_irq_mode = state_reg.dev[CSR_DA_IRQ_LSB +: 2];
  assign o_protocol = state_reg.dev[CSR_DA_PROTO_LSB +: 2];
  assign o_mem_write = state_reg.mem_we;
  assign o_parity_err = state_reg.par_err;
  assign o_chain_irq = state_reg.chain_irq;
  assign o_count_zero_irq = state_reg.zero_irq;

  logic fn_la;
  logic fn_ec;
  logic fn_ot;
  assign fn_la = i_func_valid && i_func_code == CSR_FN_LOAD_ADDR;
  assign fn_ec = i_func_valid && i_func_code == CSR_FN_ENTER_COUNT;
  assign fn_ot = i_func_valid && i_func_code == CSR_FN_OUT_TAGS;

  load_addr_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    fn_la && !i_acc[0] |=> o_start_addr0 == $past(i_acc) && !o_addr_sel)
    else $error("start address 0 not loaded");

  chain_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    fn_la && i_acc[1] && !i_transfer_end |=> o_chain_en)
    else $error("chaining not enabled");

  second_count_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    fn_la ##1 fn_ec && !i_byte_strobe ##1 fn_ec && !i_byte_strobe
    |=> o_next_count == $past(i_acc) && o_byte_count == $past(i_acc, 2))
    else $error("enter-count order wrong");

  count_zero_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    i_byte_strobe && o_byte_count == 16'h0001 && !o_chain_en
    |=> o_count_zero_irq ##1 !o_count_zero_irq)
    else $error("zero count interrupt missing");

  chain_reload_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    i_byte_strobe && o_byte_count == 16'h0001 && o_chain_en && !fn_ec
    |=> o_byte_count == $past(o_next_count) && o_addr_sel != $past(o_addr_sel)
        && o_chain_irq)
    else $error("segment reload failed");

  skip_store_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    i_read_xfer && o_skip |=> !o_mem_write)
    else $error("store during skip");

  gate_addr_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    state_reg.otag[CSR_OT_GATE_BIT]
    |=> o_bus_out == $past(o_dev_addr_mode[7:0]))
    else $error("address not on outbound bus");

  force_once_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    fn_ot && i_acc[14] ##1 i_byte_strobe && !fn_ot
    ##1 !fn_ot [*2] |-> o_bus_out_par == ~(^o_bus_out))
    else $error("parity forced beyond one byte");

  test_point_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    o_test_point && i_func_valid && !fn_ot |=> !o_test_point)
    else $error("test point not cleared");

  inhibit_par_a: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    state_reg.otag[CSR_OT_INHIBIT_BIT] |=> !o_parity_err)
    else $error("parity error reported while inhibited");

endmodule : csr_channel_setup

// [hw/csr_pkg.sv]
// constants for the channel setup function register block
// assumes a 16-bit accumulator parcel and 4-bit function codes
package csr_pkg;
  // function codes as issued by the io_processor
  localparam logic [3:0] CSR_FN_LOAD_ADDR = 4'hC;
  localparam logic [3:0] CSR_FN_ENTER_COUNT = 4'hD;
  localparam logic [3:0] CSR_FN_DEV_ADDR = 4'hE;
  localparam logic [3:0] CSR_FN_OUT_TAGS = 4'hF;
  // load-address parcel bits
  localparam int CSR_LA_SEL_BIT = 0;
  localparam int CSR_LA_CHAIN_BIT = 1;
  // device address and mode fields
  localparam int CSR_DA_ADDR_LSB = 0;
  localparam int CSR_DA_SKIP_BIT = 8;
  localparam int CSR_DA_STACK_BIT = 9;
  localparam int CSR_DA_CHAIN_LSB = 10;
  localparam int CSR_DA_IRQ_LSB = 12;
  localparam int CSR_DA_PROTO_LSB = 14;
  // output tag control fields
  localparam int CSR_OT_TAG_LSB = 0;
  localparam int CSR_OT_GATE_BIT = 10;
  localparam int CSR_OT_STROBE_BIT = 11;
  localparam int CSR_OT_CLOCK_BIT = 12;
  localparam int CSR_OT_INHIBIT_BIT = 13;
  localparam int CSR_OT_FORCE_BIT = 14;
  localparam int CSR_OT_TEST_BIT = 15;
  // values after reset
  localparam logic [15:0] CSR_RST_WORD = 16'h0000;
  localparam logic [8:0] CSR_RST_SYNC = 9'h000;
  // command chaining and protocol encodings
  localparam logic [1:0] CSR_CHAIN_NONE = 2'h0;
  localparam logic [1:0] CSR_CHAIN_CE = 2'h1;
  localparam logic [1:0] CSR_CHAIN_DE = 2'h2;
  localparam logic [1:0] CSR_CHAIN_EITHER = 2'h3;
  localparam logic [1:0] CSR_PROTO_SELECTOR = 2'h0;
  localparam logic [1:0] CSR_PROTO_STREAM = 2'h1;
  localparam logic [1:0] CSR_PROTO_BLOCK = 2'h2;
  // enter-count sequencing
  typedef enum logic [1:0] {
    CSR_EC_IDLE = 2'b00,
    CSR_EC_FIRST = 2'b01,
    CSR_EC_SECOND = 2'b10
  } csr_ec_type;
endpackage : csr_pkg

// [tb/channel_setup_function_registers_tb_top.sv]
// self-checking bench for the channel setup function registers
// assumes the far side is the peripheral model; 100 ns clock
`timescale 1ns/1ps
module channel_setup_function_registers_tb_top;
  import csr_pkg::*;
  logic clk, rstn, fv, bs, te, rd, mwr, drv, erq;
  logic [3:0] fc;
  logic [15:0] acc;
  logic [7:0] od, bin, dval;
  logic perr, bad;
  logic [9:0] tags;
  logic [7:0] bout;
  logic bpar, cko, tp, sel, cen, skip, stk, mw, pe, cirq, zirq;
  logic [15:0] sa0, sa1, cnt, ncnt, dam;
  logic [1:0] cm, im, pr;
  logic [15:0] dv;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  csr_channel_setup dut_u (.i_sys_clk(clk), .i_rstn(rstn),
    .i_func_valid(fv), .i_func_code(fc), .i_acc(acc), .i_byte_strobe(bs),
    .i_transfer_end(te), .i_read_xfer(rd), .i_mem_write_req(mwr),
    .i_out_data(od), .i_bus_in(bin), .i_bus_in_par_err(perr),
    .o_tags(tags), .o_bus_out(bout), .o_bus_out_par(bpar),
    .o_clock_out(cko), .o_test_point(tp), .o_start_addr0(sa0),
    .o_start_addr1(sa1), .o_addr_sel(sel), .o_chain_en(cen),
    .o_byte_count(cnt), .o_next_count(ncnt), .o_dev_addr_mode(dam),
    .o_skip(skip), .o_stack_status(stk), .o_chain_mode(cm),
    .o_irq_mode(im), .o_protocol(pr), .o_mem_write(mw),
    .o_parity_err(pe), .o_chain_irq(cirq), .o_count_zero_irq(zirq));
  csr_periph_model far_u (.i_clk(clk), .i_drive(drv), .i_drive_val(dval),
    .i_err_req(erq), .i_bus_out(bout), .i_bus_out_par(bpar),
    .o_bus_in(bin), .o_par_err(perr), .o_bad_par(bad));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // one function, outputs settled at the following falling edge
  task automatic func(input logic [3:0] c, input logic [15:0] a);
    @(posedge clk);
    fv <= 1'b1;
    fc <= c;
    acc <= a;
    @(posedge clk);
    fv <= 1'b0;
    @(negedge clk);
  endtask : func
  task automatic strobes(input int n);
    repeat (n) begin
      @(posedge clk);
      bs <= 1'b1;
      @(posedge clk);
      bs <= 1'b0;
    end
    @(negedge clk);
  endtask : strobes
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'b0;
    fv = 1'b0;
    bs = 1'b0;
    te = 1'b0;
    rd = 1'b0;
    mwr = 1'b0;
    drv = 1'b0;
    erq = 1'b0;
    fc = 4'h0;
    acc = 16'h0000;
    od = 8'h3C;
    dval = 8'h00;
    dv = 16'h0000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("par_rst", bpar, 1'b1);
    chk("cnt_rst", cnt, 16'h0000);
    // no chaining: count runs out and pulses once
    func(CSR_FN_LOAD_ADDR, 16'h0000);
    func(CSR_FN_ENTER_COUNT, 16'h0002);
    chk("cnt", cnt, 16'h0002);
    strobes(2);
    chk("zirq", zirq, 1'b1);
    wait_cyc(1);
    chk("zirq_end", zirq, 1'b0);
    strobes(1);
    chk("cnt_zero", cnt, 16'h0000);
    chk("zirq_idle", zirq, 1'b0);
    // a fresh load-address so the next enter-count is a first one again
    func(CSR_FN_LOAD_ADDR, 16'h0000);
    func(CSR_FN_ENTER_COUNT, 16'hFFFF);
    chk("cnt_max", cnt, 16'hFFFF);
    // chaining over two segments; the three functions go back to back
    @(posedge clk);
    fv <= 1'b1;
    fc <= CSR_FN_LOAD_ADDR;
    acc <= 16'h0102;
    @(posedge clk);
    fc <= CSR_FN_ENTER_COUNT;
    acc <= 16'h0005;
    @(posedge clk);
    acc <= 16'h0007;
    @(posedge clk);
    fv <= 1'b0;
    @(negedge clk);
    chk("sa0", sa0, 16'h0102);
    chk("sel0", sel, 1'b0);
    chk("chain", cen, 1'b1);
    chk("cnt5", cnt, 16'h0005);
    chk("ncnt", ncnt, 16'h0007);
    strobes(3);
    chk("cnt2", cnt, 16'h0002);
    chk("chain_hold", cen, 1'b1);
    strobes(2);
    chk("reload", cnt, 16'h0007);
    chk("sel1", sel, 1'b1);
    chk("cirq", cirq, 1'b1);
    @(posedge clk);
    te <= 1'b1;
    @(posedge clk);
    te <= 1'b0;
    func(CSR_FN_LOAD_ADDR, 16'h0301);
    chk("sa1", sa1, 16'h0301);
    chk("cirq_clr", cirq, 1'b0);
    // every chaining, interrupt and protocol code
    for (int i = 0; i < 4; i++) begin
      // the reserved protocol code is never written
      dv = {i[1], i[0] & ~i[1], i[1:0], i[1:0], i[0], 1'b0,
        8'h10 | 8'(i)};
      func(CSR_FN_DEV_ADDR, dv);
      chk("dam", dam, dv);
      chk("stk", stk, i[0]);
      chk("cmode", cm, i[1:0]);
      chk("imode", im, i[1:0]);
      chk("proto", pr, {i[1], i[0] & ~i[1]});
    end
    // skip blocks stores on reads
    @(posedge clk);
    rd <= 1'b1;
    mwr <= 1'b1;
    func(CSR_FN_DEV_ADDR, 16'h015A);
    wait_cyc(2);
    chk("skip", skip, 1'b1);
    chk("mw_skip", mw, 1'b0);
    func(CSR_FN_DEV_ADDR, 16'h005A);
    wait_cyc(2);
    chk("mw", mw, 1'b1);
    // output tags with gate, clock out, test point and forced parity
    func(CSR_FN_OUT_TAGS, 16'hD5A5);
    chk("tags", tags, 10'h1A5);
    chk("cko", cko, 1'b1);
    chk("tp", tp, 1'b1);
    wait_cyc(2);
    chk("gate", bout, 8'h5A);
    chk("forced", bad, 1'b1);
    strobes(1);
    wait_cyc(2);
    chk("unforced", bad, 1'b0);
    func(4'h0, 16'h0000);
    chk("tp_clr", tp, 1'b0);
    chk("cko_hold", cko, 1'b1);
    // inbound capture and parity error inhibit
    @(posedge clk);
    drv <= 1'b1;
    dval <= 8'hC3;
    erq <= 1'b1;
    func(CSR_FN_OUT_TAGS, 16'h0800);
    wait_cyc(8);
    chk("capture", dam[7:0], 8'hC3);
    chk("perr", pe, 1'b1);
    func(CSR_FN_OUT_TAGS, 16'h2000);
    wait_cyc(3);
    chk("perr_inh", pe, 1'b0);
    chk("cko_off", cko, 1'b0);
    // forced parity followed at once by a byte: only that byte is bad
    @(posedge clk);
    fv <= 1'b1;
    fc <= CSR_FN_OUT_TAGS;
    acc <= 16'h4000;
    @(posedge clk);
    fv <= 1'b0;
    bs <= 1'b1;
    @(posedge clk);
    bs <= 1'b0;
    #1;
    chk("forced_one", bad, 1'b1);
    @(posedge clk);
    #1;
    chk("forced_done", bad, 1'b0);
    wait_cyc(2);
    report_and_stop();
  end
endmodule : channel_setup_function_registers_tb_top

// [tb/csr_periph_model.sv]
// far-side peripheral control unit model on the byte-wide channel
// checks outbound parity combinationally; the inbound bus changes on rising edges of i_clk
`timescale 1ns/1ps
module csr_periph_model (
  // clock
  input wire logic i_clk,
  // control from the bench
  input wire logic i_drive,
  input wire logic [7:0] i_drive_val,
  input wire logic i_err_req,
  // outbound channel from the device
  input wire logic [7:0] i_bus_out,
  input wire logic i_bus_out_par,
  // inbound channel to the device
  output logic [7:0] o_bus_in,
  output logic o_par_err,
  output logic o_bad_par
);
  initial begin
    o_bus_in = 8'hFF;
    o_par_err = 1'b0;
  end
  always @(posedge i_clk) begin
    o_bus_in <= i_drive ? i_drive_val : ~o_bus_in;
    o_par_err <= i_err_req;
  end
  assign o_bad_par = (^{i_bus_out, i_bus_out_par}) !== 1'b1;
endmodule : csr_periph_model
